// ---- include/move_decode_pkg.sv ----
// Purpose: constants and types for the control and program move decoder
// Assumes: 24-bit instruction words held in an APB register
// Notes: register map offsets below are byte addresses
// Operation
// - ea field is a 3-bit mode plus a 3-bit pointer number
// - 5-bit control selector: 00nnn modifier, 11001..11111 control regs
// - 6-bit selector covers data, accumulator, pointer, offset, modifier, control
// - absolute short form takes a 6-bit address from the opcode
// - immediate short form loads 8 opcode bits into the control register
// - each form runs two cycles plus an addressing-dependent extra
// - one word, plus one extension word for absolute or immediate ea
// - reading stack top high decrements stack pointer after the read, unless the stack pointer is the destination
// - writing stack top high increments stack pointer before the write
// - full accumulator source goes through the status word scaler
// - extension in use saturates the value and sets the limit flag
// - limit flag stays set until reset or a write of the status word
// - single accumulator parts as source are never saturated
// - 24-bit source into 16-bit register keeps the low 16 bits
// - 24-bit value into full accumulator is sign extended, low zeros
// - 16-bit source into 24-bit register has upper 8 bits zeroed
// - middle accumulator word as destination writes only that word
// - new pointer, offset or modifier values usable by the next move
package move_decode_pkg;
    // register map
    localparam logic [7:0] OFS_INSTR  = 8'h00;
    localparam logic [7:0] OFS_EXT    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_SEL    = 8'h0c;
    localparam logic [7:0] OFS_DATA   = 8'h10;
    // opcode high bytes
    localparam logic [7:0] OP_CTL_REG = 8'h04;
    localparam logic [7:0] OP_CTL_MEM = 8'h05;
    localparam logic [7:0] OP_PRG_MEM = 8'h07;
    // effective address modes
    localparam logic [2:0] EA_PDN     = 3'h0;
    localparam logic [2:0] EA_PIN     = 3'h1;
    localparam logic [2:0] EA_PD      = 3'h2;
    localparam logic [2:0] EA_PI      = 3'h3;
    localparam logic [2:0] EA_IDX     = 3'h5;
    localparam logic [2:0] EA_SPC     = 3'h6;
    localparam logic [2:0] EA_PRE     = 3'h7;
    localparam logic [2:0] EA_ABS_R   = 3'h0;
    localparam logic [2:0] EA_IMM_R   = 3'h4;
    // general register selector codes
    localparam logic [5:0] G_X0       = 6'h04;
    localparam logic [5:0] G_X1       = 6'h05;
    localparam logic [5:0] G_Y0       = 6'h06;
    localparam logic [5:0] G_Y1       = 6'h07;
    localparam logic [5:0] G_A0       = 6'h08;
    localparam logic [5:0] G_B0       = 6'h09;
    localparam logic [5:0] G_A2       = 6'h0a;
    localparam logic [5:0] G_B2       = 6'h0b;
    localparam logic [5:0] G_A1       = 6'h0c;
    localparam logic [5:0] G_B1       = 6'h0d;
    localparam logic [5:0] G_A        = 6'h0e;
    localparam logic [5:0] G_B        = 6'h0f;
    localparam logic [2:0] G_R        = 3'h2;
    localparam logic [2:0] G_N        = 3'h3;
    localparam logic [2:0] G_M        = 3'h4;
    localparam logic [2:0] G_CTL      = 3'h7;
    localparam logic [5:0] G_SR       = 6'h39;
    localparam logic [5:0] G_OMR      = 6'h3a;
    localparam logic [5:0] G_SP       = 6'h3b;
    localparam logic [5:0] G_SSH      = 6'h3c;
    localparam logic [5:0] G_SSL      = 6'h3d;
    localparam logic [5:0] G_LA       = 6'h3e;
    localparam logic [5:0] G_LC       = 6'h3f;
    // status word fields
    localparam int         SR_L_BIT   = 6;
    localparam int         SR_S0_BIT  = 10;
    localparam int         SR_S1_BIT  = 11;
    localparam logic [23:0] SAT_POS   = 24'h7fffff;
    localparam logic [23:0] SAT_NEG   = 24'h800000;
    // timing and reset values
    localparam logic [3:0] MVC_BASE   = 4'h2;
    localparam logic [3:0] MVC_EXT    = 4'h2;
    localparam logic [15:0] RST_CTL   = 16'h0000;

    typedef enum logic [1:0] {SPC_X, SPC_Y, SPC_P} space_t;

    typedef struct packed {
        logic        req;
        logic        we;
        space_t      space;
        logic [15:0] addr;
        logic [23:0] wdata;
    } mem_req_t;
endpackage

// ---- rtl/control_and_program_move_decode.sv ----
// Purpose: executes control register and program memory moves
// Assumes: mem_rdata valid in the same cycle as mem.req
// Notes: pointer arithmetic is linear, modifiers are stored only
`timescale 1ns/100ps
`default_nettype none
module control_and_program_move_decode #(
    parameter int STACK_DEPTH = 16
) (
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // data and program memory
    output move_decode_pkg::mem_req_t      mem,
    input  wire logic [23:0]               mem_rdata,
    // execution state
    output logic                           busy
);
    import move_decode_pkg::*;

    localparam int SPI = $clog2(STACK_DEPTH);

    typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_DONE} state_t;

    state_t      state_reg;
    state_t      state_next;
    logic [23:0] instr_reg;
    logic [23:0] ext_reg;
    logic [5:0]  sel_reg;
    logic [3:0]  cnt_reg;
    logic [3:0]  len_reg;
    logic [3:0]  run_cnt_reg;
    logic [1:0]  words_reg;
    logic        ill_flag_reg;
    logic        lim_reg;
    logic [15:0] r_reg [8];
    logic [15:0] n_reg [8];
    logic [15:0] m_reg [8];
    logic [23:0] x0_reg;
    logic [23:0] x1_reg;
    logic [23:0] y0_reg;
    logic [23:0] y1_reg;
    logic [55:0] a_reg;
    logic [55:0] b_reg;
    logic [15:0] sr_reg;
    logic [15:0] sr_next;
    logic [15:0] omr_reg;
    logic [15:0] la_reg;
    logic [15:0] lc_reg;
    logic [5:0]  sp_reg;
    logic [5:0]  sp_next;
    logic [15:0] ssh_reg [STACK_DEPTH];
    logic [15:0] ssl_reg [STACK_DEPTH];
    mem_req_t    mem_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        busy_reg;
    logic [31:0] rd_mux;
    logic [15:0] ea_addr;
    logic [15:0] ea_upd;

    // scaler then limiter, bit 24 flags limiting
    function automatic logic [24:0] limit_fn(input logic [55:0] acc,
                                             input logic [1:0]  sc);
        logic [55:0] s;
        s = (sc == 2'b01) ? {acc[55], acc[55:1]} :
            (sc == 2'b10) ? {acc[54:0], 1'b0} : acc;
        if (s[55:47] == {9{s[55]}})
            return {1'b0, s[47:24]};
        return {1'b1, s[55] ? SAT_NEG : SAT_POS};
    endfunction

    function automatic logic [5:0] ctl_fn(input logic [4:0] d);
        return {d[4] ? G_CTL : G_M, d[2:0]};
    endfunction

    function automatic logic ctl_ok_fn(input logic [4:0] d);
        return d[4:3] == 2'b00 || (d[4:3] == 2'b11 && d[2:0] != 3'h0);
    endfunction

    function automatic logic valid_fn(input logic [5:0] c);
        return (c >= G_X0 && c <= G_B) || c[5:3] == G_R ||
               c[5:3] == G_N || c[5:3] == G_M ||
               (c[5:3] == G_CTL && c[2:0] != 3'h0);
    endfunction

    function automatic logic is16_fn(input logic [5:0] c);
        return c[5:4] != 2'b00;
    endfunction

    wire [24:0] a_lim = limit_fn(a_reg, {sr_reg[SR_S1_BIT], sr_reg[SR_S0_BIT]});
    wire [24:0] b_lim = limit_fn(b_reg, {sr_reg[SR_S1_BIT], sr_reg[SR_S0_BIT]});
    wire [SPI-1:0] sp_idx = sp_reg[SPI-1:0];

    // 16-bit registers read back with a zeroed top byte
    function automatic logic [23:0] rd_fn(input logic [5:0] c);
        if (c[5:3] == G_R) return {8'h00, r_reg[c[2:0]]};
        if (c[5:3] == G_N) return {8'h00, n_reg[c[2:0]]};
        if (c[5:3] == G_M) return {8'h00, m_reg[c[2:0]]};
        case (c)
            G_X0:    return x0_reg;
            G_X1:    return x1_reg;
            G_Y0:    return y0_reg;
            G_Y1:    return y1_reg;
            G_A0:    return a_reg[23:0];
            G_B0:    return b_reg[23:0];
            G_A2:    return {{16{a_reg[55]}}, a_reg[55:48]};
            G_B2:    return {{16{b_reg[55]}}, b_reg[55:48]};
            G_A1:    return a_reg[47:24];
            G_B1:    return b_reg[47:24];
            G_A:     return a_lim[23:0];
            G_B:     return b_lim[23:0];
            G_SR:    return {8'h00, sr_reg};
            G_OMR:   return {8'h00, omr_reg};
            G_SP:    return {18'h0, sp_reg};
            G_SSH:   return {8'h00, ssh_reg[sp_idx]};
            G_SSL:   return {8'h00, ssl_reg[sp_idx]};
            G_LA:    return {8'h00, la_reg};
            G_LC:    return {8'h00, lc_reg};
            default: return 24'h0;
        endcase
    endfunction

    // opcode decode
    wire [7:0] op_hi  = instr_reg[23:16];
    wire       w_bit  = instr_reg[15];
    wire       s_bit  = instr_reg[6];
    wire f_cmem = op_hi == OP_CTL_MEM && !instr_reg[7] && instr_reg[5];
    wire f_cimm = op_hi == OP_CTL_MEM && instr_reg[7:5] == 3'b101;
    wire f_creg = op_hi == OP_CTL_REG && instr_reg[14] &&
                  instr_reg[7:5] == 3'b101;
    wire f_pea  = op_hi == OP_PRG_MEM && instr_reg[14] &&
                  instr_reg[7:6] == 2'b10;
    wire f_paa  = op_hi == OP_PRG_MEM && !instr_reg[14] &&
                  instr_reg[7:6] == 2'b00;
    wire f_prg  = f_pea | f_paa;
    wire f_mem  = f_cmem | f_prg;
    wire use_ea = instr_reg[14] && f_mem;
    wire [2:0] ea_mode = instr_reg[13:11];
    wire [2:0] ea_rn   = instr_reg[10:8];
    wire ea_spc  = use_ea && ea_mode == EA_SPC;
    wire ea_abs  = ea_spc && ea_rn == EA_ABS_R;
    wire ea_imm  = ea_spc && ea_rn == EA_IMM_R && f_cmem;
    wire has_ext = ea_abs | ea_imm;
    wire to_mem  = f_mem && !w_bit;
    wire [5:0] gcode = f_prg ? instr_reg[5:0] : ctl_fn(instr_reg[4:0]);
    wire [5:0] ecode = instr_reg[13:8];
    wire [5:0] dst_code = (f_creg && !w_bit) ? ecode : gcode;
    wire [5:0] src_code = (f_creg && w_bit) ? ecode : gcode;
    wire src_is_reg = f_creg | to_mem;
    wire ill = !(f_mem | f_cimm | f_creg) || !valid_fn(gcode) ||
               (f_creg && !valid_fn(ecode)) ||
               (!f_prg && !ctl_ok_fn(instr_reg[4:0])) ||
               (ea_spc && !has_ext) || (ea_imm && to_mem) ||
               (f_creg && src_code == G_SSH && dst_code == G_SSH);
    wire [24:0] src_lim = {(src_code == G_A && a_lim[24]) ||
                           (src_code == G_B && b_lim[24]),
                           rd_fn(src_code)};
    wire [23:0] mv_val = f_cimm ? {16'h0, instr_reg[15:8]} :
                         !f_mem ? src_lim[23:0] :
                         ea_imm ? ext_reg : mem_rdata;

    // apb decode
    wire idle     = state_reg == S_IDLE;
    wire apb_acc  = psel && penable;
    wire apb_ask  = apb_acc && !pready_reg;
    wire apb_ok   = apb_acc && pready_reg && pwrite && !pslverr_reg;
    wire map_hit  = paddr == OFS_INSTR || paddr == OFS_EXT ||
                    paddr == OFS_STATUS || paddr == OFS_SEL ||
                    paddr == OFS_DATA;
    // writes that would disturb a running move are refused
    wire refuse   = pwrite && (paddr == OFS_STATUS ||
                    (!idle && paddr != OFS_SEL));
    wire start    = apb_ok && paddr == OFS_INSTR;
    wire apb_dat  = apb_ok && paddr == OFS_DATA;

    // register write port shared by execution and apb
    wire exec_wr = state_reg == S_DONE && !ill && !to_mem;
    wire wr_en   = exec_wr | apb_dat;
    wire [5:0]  wr_code = exec_wr ? dst_code : sel_reg;
    wire [23:0] wr_val  = exec_wr ? mv_val : pwdata[23:0];
    wire sr_wr   = wr_en && wr_code == G_SR;
    wire sp_wr   = wr_en && wr_code == G_SP;
    wire push    = exec_wr && dst_code == G_SSH;
    wire pop     = state_reg == S_DONE && !ill && src_is_reg &&
                   src_code == G_SSH;
    wire set_l   = state_reg == S_DONE && lim_reg;
    wire mem_go  = f_mem && !ill && !ea_imm;

    always_comb begin
        case (ea_mode)
            EA_PDN: begin ea_addr = r_reg[ea_rn]; ea_upd = r_reg[ea_rn] - n_reg[ea_rn]; end
            EA_PIN: begin ea_addr = r_reg[ea_rn]; ea_upd = r_reg[ea_rn] + n_reg[ea_rn]; end
            EA_PD:  begin ea_addr = r_reg[ea_rn]; ea_upd = r_reg[ea_rn] - 16'h1; end
            EA_PI:  begin ea_addr = r_reg[ea_rn]; ea_upd = r_reg[ea_rn] + 16'h1; end
            EA_IDX: begin ea_addr = r_reg[ea_rn] + n_reg[ea_rn]; ea_upd = r_reg[ea_rn]; end
            EA_PRE: begin ea_addr = r_reg[ea_rn] - 16'h1; ea_upd = ea_addr; end
            EA_SPC: begin ea_addr = ext_reg[15:0]; ea_upd = r_reg[ea_rn]; end
            default: begin ea_addr = r_reg[ea_rn]; ea_upd = r_reg[ea_rn]; end
        endcase
    end

    always_comb begin
        case (state_reg)
            S_IDLE:  state_next = start ? S_ISSUE : S_IDLE;
            S_ISSUE: state_next = has_ext ? S_WAIT : S_DONE;
            S_WAIT:  state_next = cnt_reg == 4'h0 ? S_DONE : S_WAIT;
            S_DONE:  state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    always_comb begin
        sr_next = sr_wr ? wr_val[15:0] : sr_reg;
        sr_next = sr_next | (16'(set_l) << SR_L_BIT);
        sp_next = sp_wr ? wr_val[5:0] :
                  push ? sp_reg + 6'h01 :
                  pop ? sp_reg - 6'h01 : sp_reg;
    end

    always_comb begin
        case (paddr)
            OFS_INSTR:  rd_mux = {8'h00, instr_reg};
            OFS_EXT:    rd_mux = {8'h00, ext_reg};
            OFS_STATUS: rd_mux = {24'h0, len_reg, words_reg,
                                  ill_flag_reg, busy_reg};
            OFS_SEL:    rd_mux = {26'h0, sel_reg};
            OFS_DATA:   rd_mux = {8'h00, rd_fn(sel_reg)};
            default:    rd_mux = 32'h0;
        endcase
    end

    // apb slave, one wait state so read data comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            pready_reg  <= apb_ask;
            pslverr_reg <= apb_ask && (!map_hit || refuse);
            prdata_reg  <= (apb_ask && !pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= S_IDLE;
            busy_reg     <= 1'b0;
            instr_reg    <= 24'h0;
            ext_reg      <= 24'h0;
            sel_reg      <= 6'h0;
            cnt_reg      <= 4'h0;
            len_reg      <= 4'h0;
            run_cnt_reg  <= 4'h0;
            words_reg    <= 2'h0;
            ill_flag_reg <= 1'b0;
            lim_reg      <= 1'b0;
            mem_reg      <= '0;
        end else begin
            state_reg   <= state_next;
            busy_reg    <= state_next != S_IDLE;
            run_cnt_reg <= start ? 4'h0 : run_cnt_reg + 4'h1;
            cnt_reg     <= (state_reg == S_ISSUE) ? MVC_EXT - 4'h1 :
                           cnt_reg - 4'(cnt_reg != 4'h0);
            mem_reg.req <= state_next == S_DONE && mem_go;
            if (start) instr_reg <= pwdata[23:0];
            if (apb_ok && paddr == OFS_EXT) ext_reg <= pwdata[23:0];
            if (apb_ok && paddr == OFS_SEL) sel_reg <= pwdata[5:0];
            if (state_reg == S_DONE) ill_flag_reg <= ill;
            if (state_reg == S_ISSUE) begin
                len_reg   <= MVC_BASE + (has_ext ? MVC_EXT : 4'h0);
                words_reg <= has_ext ? 2'h2 : 2'h1;
                lim_reg   <= src_is_reg && !ill && src_lim[24];
                mem_reg.we    <= to_mem;
                mem_reg.space <= f_prg ? SPC_P : s_bit ? SPC_Y : SPC_X;
                mem_reg.addr  <= use_ea ? ea_addr
                                        : {10'h0, instr_reg[13:8]};
                mem_reg.wdata <= src_lim[23:0];
            end
        end
    end

    // architectural registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                r_reg[i] <= RST_CTL;
                n_reg[i] <= RST_CTL;
                m_reg[i] <= RST_CTL;
            end
            for (int i = 0; i < STACK_DEPTH; i++) begin
                ssh_reg[i] <= RST_CTL;
                ssl_reg[i] <= RST_CTL;
            end
            {x0_reg, x1_reg, y0_reg, y1_reg} <= '0;
            {a_reg, b_reg} <= '0;
            {sr_reg, omr_reg, la_reg, lc_reg} <= '0;
            sp_reg <= 6'h0;
        end else begin
            sr_reg <= sr_next;
            sp_reg <= sp_next;
            if (state_reg == S_ISSUE && use_ea && !ea_spc && !ill)
                r_reg[ea_rn] <= ea_upd;
            if (wr_en) begin
                // new values are usable by the very next move
                if (wr_code[5:3] == G_R) r_reg[wr_code[2:0]] <= wr_val[15:0];
                if (wr_code[5:3] == G_N) n_reg[wr_code[2:0]] <= wr_val[15:0];
                if (wr_code[5:3] == G_M) m_reg[wr_code[2:0]] <= wr_val[15:0];
                case (wr_code)
                    G_X0:  x0_reg <= wr_val;
                    G_X1:  x1_reg <= wr_val;
                    G_Y0:  y0_reg <= wr_val;
                    G_Y1:  y1_reg <= wr_val;
                    G_A0:  a_reg[23:0] <= wr_val;
                    G_B0:  b_reg[23:0] <= wr_val;
                    G_A2:  a_reg[55:48] <= wr_val[7:0];
                    G_B2:  b_reg[55:48] <= wr_val[7:0];
                    G_A1:  a_reg[47:24] <= wr_val;
                    G_B1:  b_reg[47:24] <= wr_val;
                    G_A:   a_reg <= {{8{wr_val[23]}}, wr_val, 24'h0};
                    G_B:   b_reg <= {{8{wr_val[23]}}, wr_val, 24'h0};
                    G_OMR: omr_reg <= wr_val[15:0];
                    G_LA:  la_reg <= wr_val[15:0];
                    G_LC:  lc_reg <= wr_val[15:0];
                    G_SSH: ssh_reg[sp_next[SPI-1:0]] <= wr_val[15:0];
                    G_SSL: ssl_reg[sp_idx] <= wr_val[15:0];
                    default: ;
                endcase
            end
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign mem     = mem_reg;
    assign busy    = busy_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_exec_length:
    assert property (state_reg == S_DONE |-> run_cnt_reg + 4'h1 == len_reg)
        else $error("move length differs from cycle count");
    a_word_count:
    assert property (state_reg == S_ISSUE && has_ext |=> words_reg == 2'h2)
        else $error("extension word not counted");
    a_stack_pop:
    assert property (pop && !sp_wr |=> sp_reg == $past(sp_reg) - 6'h01)
        else $error("stack pointer not decremented after read");
    a_stack_push:
    assert property (push |=> sp_reg == $past(sp_reg) + 6'h01 &&
                     ssh_reg[sp_idx] == $past(wr_val[15:0]))
        else $error("stack top not pushed");
    a_short_addr:
    assert property (mem_reg.req && !instr_reg[14] |->
                     mem_reg.addr == {10'h0, instr_reg[13:8]})
        else $error("absolute short address wrong");
    a_limit_flag:
    assert property (state_reg == S_ISSUE && src_is_reg && !ill &&
                     src_lim[24] |-> ##[1:3] sr_reg[SR_L_BIT])
        else $error("limit flag not set after saturation");
    a_sat_value:
    assert property (src_lim[24] |-> src_lim[23:0] == SAT_POS ||
                     src_lim[23:0] == SAT_NEG)
        else $error("saturated value wrong");
    a_limit_sticky:
    assert property (sr_reg[SR_L_BIT] && !sr_wr |=> sr_reg[SR_L_BIT])
        else $error("limit flag lost");
    a_part_nolimit:
    assert property (src_lim[24] |-> src_code == G_A || src_code == G_B)
        else $error("accumulator part was limited");
    a_acc_extend:
    assert property (exec_wr && dst_code == G_A |=> a_reg[23:0] == 24'h0 &&
                     a_reg[55:48] == {8{a_reg[47]}})
        else $error("accumulator not extended");
    a_zero_fill:
    assert property (exec_wr && dst_code == G_X0 && is16_fn(src_code) &&
                     f_creg |=> x0_reg[23:16] == 8'h0)
        else $error("upper byte not cleared");
    a_mid_only:
    assert property (exec_wr && dst_code == G_A1 |=>
                     a_reg[55:48] == $past(a_reg[55:48]) &&
                     a_reg[23:0] == $past(a_reg[23:0]))
        else $error("middle word write touched other parts");

    c_start: cover property (start);
    c_ext_move: cover property (state_reg == S_ISSUE && has_ext);
    c_limit: cover property (set_l);
    c_push: cover property (push);
endmodule
`default_nettype wire

// ---- tb/prog_mem_model.sv ----
// Purpose: memory on the far side of the move decoder
// Assumes: slot index is space plus low six address bits
// Notes: idle bus shows inverted data so stale reads fail
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model (
    input  wire logic                      pclk,
    input  wire move_decode_pkg::mem_req_t mem,
    output logic [23:0]                    mem_rdata
);
    logic [23:0] m [256];
    logic [7:0]  idx;
    assign idx = {mem.space, mem.addr[5:0]};
    initial for (int i = 0; i < 256; i++) m[i] = 24'h800000 | 24'(i);
    assign mem_rdata = mem.req ? m[idx] : ~m[idx];
    always @(posedge pclk) if (mem.req && mem.we) m[idx] <= mem.wdata;
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the move decoder
// Assumes: far side is the memory model
// Notes: each row preloads a register, runs a move, checks its length and one result
`timescale 1ns/100ps
`default_nettype none
module tb;
    import move_decode_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, busy, pready, pslverr, err, ext;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, got;
    logic [23:0] mem_rdata;
    mem_req_t    mem;
    int          miscompares = 0, total_checks = 0, c;
    typedef struct packed {logic [5:0] ps; logic [23:0] pv, ins;
        logic [8:0] ck; logic [23:0] ev;} row_t;
    row_t rows [12] = '{ // ck[8] reads memory slot ck[7:0] instead of a register
        '{6'h3f,24'h100,24'h0444bf,9'h004,24'h100},
        '{6'h05,24'habcdef,24'h04c5be,9'h03e,24'hcdef},
        '{6'h3f,24'h0,24'h05abbf,9'h03f,24'hab},
        '{6'h3b,24'h3,24'h07853c,9'h03b,24'h4},
        '{6'h3b,24'h4,24'h07063c,9'h03b,24'h3},
        '{6'h12,24'h10,24'h05da21,9'h012,24'h11},
        '{6'h0a,24'h1,24'h07070e,9'h187,24'h7fffff},
        '{6'h0c,24'h123456,24'h07080c,9'h188,24'h123456},
        '{6'h08,24'hffffff,24'h07890e,9'h008,24'h0},
        '{6'h3f,24'h0,24'h070a0e,9'h18a,24'h800089},
        '{6'h21,24'h1234,24'h050b61,9'h14b,24'h1234},
        '{6'h21,24'h0,24'h05f021,9'h021,24'h20}
    };
    control_and_program_move_decode dut_u (.*);
    prog_mem_model pm_u (.*);
    initial forever #2.5 pclk = ~pclk;
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        miscompares += (g !== e);
        if (g !== e) $display("MISMATCH %s expected %h seen %h", n, e, g);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic bound(int n);
        miscompares += (n >= 50);
        if (n >= 50) end_of_test();
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 1; pready !== 1'b1 && n < 50; n++) @(posedge pclk);
        {got, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
        bound(n);
    endtask
    task automatic run(logic [23:0] ins);
        apb(1'b1, OFS_INSTR, {8'h00, ins});
        @(posedge pclk);
        for (c = 1; busy === 1'b1 && c < 50; c++) @(posedge pclk);
        bound(c);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, OFS_EXT, 32'h20);
        foreach (rows[i]) begin
            apb(1'b1, OFS_SEL, {26'h0, rows[i].ps});
            apb(1'b1, OFS_DATA, {8'h00, rows[i].pv});
            run(rows[i].ins);
            ext = {rows[i].ins[23:16], rows[i].ins[14:11]} == 12'h05e;
            chk("length", ext ? 32'h4 : 32'h2, c);
            apb(1'b1, OFS_SEL, {26'h0, rows[i].ck[5:0]});
            apb(1'b0, OFS_DATA, 32'h0);
            if (rows[i].ck[8]) got = {8'h00, pm_u.m[rows[i].ck[7:0]]};
            chk("result", {8'h00, rows[i].ev}, got);
        end
        apb(1'b1, OFS_SEL, 32'h39);
        apb(1'b0, OFS_DATA, 32'h0);
        chk("limit", 32'h40, got & 32'h40);
        run(24'h047cbc);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("illegal", 32'h2, got & 32'h2);
        apb(1'b1, 8'h14, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        // reset while idle must clear state and selector
        presetn <= 1'b0;
        @(posedge pclk);
        chk("reset busy", 32'h0, {31'h0, busy});
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_SEL, 32'h0);
        chk("reset sel", 32'h0, got);
        end_of_test();
    end
endmodule
`default_nettype wire
